// ---- rtl/fpu_exc_params.svh ----
// Purpose: constants for the fpu exception and conditional move unit
// Assumes: control/status word laid out as the classic fp status register
// Notes:   field positions, encodings, reset and write mask values, single precision special values only
`ifndef FPU_EXC_PARAMS_SVH
`define FPU_EXC_PARAMS_SVH

// ==========================================================
// control/status word fields
`define CSR_RM_LSB      0
`define CSR_FLAG_LSB    2
`define CSR_EN_LSB      7
`define CSR_CAUSE_LSB   12
`define CSR_CC0_BIT     23
`define CSR_FN_BIT      21
`define CSR_CC_HI_LSB   25
`define CSR_RESET       32'h0000_0000
`define CSR_WMASK       32'hfeaf_ffff

// ==========================================================
// condition bit positions inside a five/six bit field
`define EXC_I           0
`define EXC_U           1
`define EXC_O           2
`define EXC_Z           3
`define EXC_V           4
`define EXC_E           5

// ==========================================================
// rounding modes
`define RM_NEAREST      2'h0
`define RM_NOUGHT       2'h1
`define RM_UP           2'h2
`define RM_DOWN         2'h3

// ==========================================================
// single precision special values, sign added separately except SP_QNAN, which holds all 32 bits
`define SP_INF          31'h7f80_0000
`define SP_MAXFIN       31'h7f7f_ffff
`define SP_SMALLEST_NORMAL_VALUE      31'h0080_0000
`define SP_ZERO         31'h0000_0000
`define SP_QNAN         32'h7fc0_0000

`endif

// ---- rtl/fpu_exc_pkg.sv ----
// Purpose: types shared by the fpu exception and conditional move unit
// Assumes: nothing beyond the params header
// Notes:   operation kinds dispatched by the integer pipeline
package fpu_exc_pkg;

    // ==========================================================
    // operation kinds
    typedef enum logic [3:0] {
        op_none,
        op_arith,
        fp_plain_move,
        fp_move_if_cc_false,
        fp_move_if_cc_true,
        fp_move_if_gpr_nonzero,
        fp_move_if_gpr_zero,
        int_move_on_cc_false,
        int_move_on_cc_true,
        branch_on_cc_false,
        branch_on_cc_true,
        branch_likely_on_cc_false,
        branch_likely_on_cc_true
    } op_kind_e;

    typedef logic [1:0] fmt_t;

endpackage : fpu_exc_pkg

// ---- rtl/fpu_exception_and_cond_move.sv ----
// Purpose: fp exception fields, traps, default results, moves and cc branches
// Assumes: one op dispatched per cycle when op_valid is high
// Notes:   arithmetic datapath supplies raw conditions and rounded result
`timescale 1ns/1ps
`include "fpu_exc_params.svh"

module fpu_exception_and_cond_move
    import fpu_exc_pkg::*;
(
    input  wire logic        clk,              // core clock
    input  wire logic        rst_n,            // async reset, active low
    input  wire logic        op_valid,         // op dispatched this cycle
    input  wire op_kind_e    op_kind,          // kind of op
    input  wire logic [5:0]  op_cond,          // raw conditions e,v,z,o,u,i
    input  wire logic [31:0] op_result,        // rounded result from datapath
    input  wire logic        op_sign,          // sign of exact result
    input  wire logic [2:0]  cc_sel,           // condition code selected
    input  wire logic        cmp_valid,        // compare writes a code
    input  wire logic        cmp_true,         // compare outcome
    input  wire logic [31:0] gpr_value,        // integer register tested
    input  wire logic [4:0]  dst_idx,          // fp destination register
    input  wire logic [31:0] src_value,        // move source value
    input  wire fmt_t        op_fmt,           // format of the move
    input  wire logic [31:0] branch_pc,        // pc of the branch
    input  wire logic [31:0] branch_offset,    // sign-extended byte offset
    input  wire logic        csr_wr,           // software writes status word
    input  wire logic [31:0] csr_wdata,        // written status word
    output logic [31:0]      fp_control_status_reg, // status word
    output logic             trap_req,         // trap request, combinational
    output logic             result_we,        // result commit pulse
    output logic [31:0]      result_data,      // committed result
    output logic [4:0]       result_idx,       // committed destination
    output logic             result_undef,     // committed value undefined
    output logic             int_move_we,      // integer move commit pulse
    output logic [31:0]      int_move_data,    // integer move value
    output logic             branch_taken,     // branch redirect pulse
    output logic [31:0]      branch_target,    // redirect target
    output logic             delay_slot_nullify, // kill delay slot pulse
    output logic             cond_error        // illegal condition mix seen
);

    // ==========================================================
    // status fields
    logic [4:0] flags;
    logic [4:0] enables;
    logic [5:0] cause;
    logic [7:0] cc;
    logic [1:0] rmode;
    logic       fn_bit;
    fmt_t       reg_fmt [32];

    // ==========================================================
    // helpers
    function automatic logic cc_pick(input logic [7:0] c, input logic [2:0] s);
        cc_pick = c[s];
    endfunction : cc_pick

    // filter raw conditions into a cause word: E set clears every other bit, else raw passes unchanged
    function automatic logic [5:0] shape_cause(input logic [5:0] raw);
        logic [5:0] r;
        r = raw;
        if (raw[`EXC_E]) begin
            r = 6'h20;
        end
        shape_cause = r;
    endfunction : shape_cause

    // ==========================================================
    // trap detection
    logic [5:0] new_cause;
    logic       arith_op;
    logic       op_trap;
    logic       wr_trap;
    logic [4:0] wr_en;
    logic [5:0] wr_cause;
    logic       stall;

    assign arith_op  = op_valid && (op_kind == op_arith);
    assign new_cause = shape_cause(op_cond);
    assign wr_en     = csr_wdata[`CSR_EN_LSB +: 5];
    assign wr_cause  = csr_wdata[`CSR_CAUSE_LSB +: 6];
    assign op_trap = arith_op && ((|(new_cause[4:0] & enables)) || new_cause[`EXC_E]);
    assign wr_trap = csr_wr && ((|(wr_cause[4:0] & wr_en)) || wr_cause[`EXC_E]);
    assign trap_req = op_trap || wr_trap;
    assign stall = trap_req;

    assign cond_error = arith_op && !new_cause[`EXC_E]
        && ($countones(new_cause[`EXC_V:`EXC_U]) > 1
            || (new_cause[`EXC_O] && new_cause[`EXC_U])
            || ((new_cause[`EXC_V] || new_cause[`EXC_Z]) && new_cause[`EXC_I]));

    // ==========================================================
    // cause field
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cause <= 6'h00;
        end else if (csr_wr) begin
            cause <= wr_cause;
        end else if (arith_op) begin
            cause <= new_cause;
        end
    end

    // enables, rounding, flush bit
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            enables <= 5'h00;
            rmode   <= `RM_NEAREST;
            fn_bit  <= 1'b0;
        end else if (csr_wr) begin
            enables <= wr_en;
            rmode   <= csr_wdata[`CSR_RM_LSB +: 2];
            fn_bit  <= csr_wdata[`CSR_FN_BIT];
        end
    end

    // sticky flags
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flags <= 5'h00;
        end else if (csr_wr) begin
            flags <= csr_wdata[`CSR_FLAG_LSB +: 5];
        end else if (arith_op && !op_trap) begin
            flags <= flags | new_cause[4:0];
        end
    end

    // condition codes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cc <= 8'h00;
        end else if (csr_wr) begin
            // code 0 apart from codes 1 to 7
            cc <= {csr_wdata[`CSR_CC_HI_LSB +: 7], csr_wdata[`CSR_CC0_BIT]};
        end else if (cmp_valid) begin
            cc[cc_sel] <= cmp_true;
        end
    end

    always_comb begin
        fp_control_status_reg = `CSR_RESET;
        fp_control_status_reg[`CSR_RM_LSB +: 2]     = rmode;
        fp_control_status_reg[`CSR_FLAG_LSB +: 5]   = flags;
        fp_control_status_reg[`CSR_EN_LSB +: 5]     = enables;
        fp_control_status_reg[`CSR_CAUSE_LSB +: 6]  = cause;
        fp_control_status_reg[`CSR_FN_BIT]          = fn_bit;
        fp_control_status_reg[`CSR_CC0_BIT]         = cc[0];
        fp_control_status_reg[`CSR_CC_HI_LSB +: 7]  = cc[7:1];
    end

    // ==========================================================
    // default results
    logic [31:0] default_result;
    always_comb begin
        default_result = op_result;
        if (new_cause[`EXC_V]) begin
            default_result = `SP_QNAN;
        end else if (new_cause[`EXC_Z]) begin
            default_result = {op_sign, `SP_INF};
        end else if (new_cause[`EXC_O]) begin
            unique case (rmode)
                `RM_NEAREST: default_result = {op_sign, `SP_INF};
                `RM_NOUGHT:  default_result = {op_sign, `SP_MAXFIN};
                `RM_UP:      default_result = op_sign ? {1'b1, `SP_MAXFIN} : {1'b0, `SP_INF};
                `RM_DOWN:    default_result = op_sign ? {1'b1, `SP_INF} : {1'b0, `SP_MAXFIN};
            endcase
        end else if (new_cause[`EXC_U] && !fn_bit) begin
            unique case (rmode)
                `RM_NEAREST: default_result = {op_sign, `SP_ZERO};
                `RM_NOUGHT:  default_result = {op_sign, `SP_ZERO};
                `RM_UP:      default_result = op_sign ? {1'b0, `SP_ZERO} : {1'b0, `SP_SMALLEST_NORMAL_VALUE};
                `RM_DOWN:    default_result = op_sign ? {1'b1, `SP_SMALLEST_NORMAL_VALUE} : {1'b1, `SP_ZERO};
            endcase
        end
    end

    // ==========================================================
    // move and branch decode
    logic cc_bit;
    logic move_go;
    logic is_fmove;
    logic is_branch;
    logic is_likely;
    logic br_go;
    assign cc_bit = cc_pick(cc, cc_sel);

    always_comb begin
        move_go   = 1'b0;
        is_fmove  = 1'b0;
        is_branch = 1'b0;
        is_likely = 1'b0;
        br_go     = 1'b0;
        unique case (op_kind)
            fp_plain_move:           begin is_fmove = 1'b1; move_go = 1'b1; end
            fp_move_if_cc_false:     begin is_fmove = 1'b1; move_go = !cc_bit; end
            fp_move_if_cc_true:      begin is_fmove = 1'b1; move_go = cc_bit; end
            fp_move_if_gpr_nonzero:  begin is_fmove = 1'b1; move_go = |gpr_value; end
            fp_move_if_gpr_zero:     begin is_fmove = 1'b1; move_go = ~|gpr_value; end
            int_move_on_cc_false:    move_go = !cc_bit;
            int_move_on_cc_true:     move_go = cc_bit;
            branch_on_cc_false:      begin is_branch = 1'b1; br_go = !cc_bit; end
            branch_on_cc_true:       begin is_branch = 1'b1; br_go = cc_bit; end
            branch_likely_on_cc_false: begin
                is_branch = 1'b1;
                is_likely = 1'b1;
                br_go     = !cc_bit;
            end
            branch_likely_on_cc_true: begin
                is_branch = 1'b1;
                is_likely = 1'b1;
                br_go     = cc_bit;
            end
            default: ;
        endcase
    end

    // format tags of fp registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int k = 0; k < 32; k++) begin
                reg_fmt[k] <= 2'h0;
            end
        end else if (op_valid && is_fmove && !stall) begin
            reg_fmt[dst_idx] <= op_fmt;
        end
    end

    // fp result commit
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            result_we    <= 1'b0;
            result_data  <= 32'h0000_0000;
            result_idx   <= 5'h00;
            result_undef <= 1'b0;
        end else begin
            // no write on trap, default result stored
            result_we    <= op_valid && !stall && ((arith_op) || (is_fmove && move_go));
            result_idx   <= dst_idx;
            result_data  <= arith_op ? default_result : src_value;
            // undefined when format changes without a move
            result_undef <= op_valid && is_fmove && (op_kind != fp_plain_move)
                            && !move_go && (reg_fmt[dst_idx] != op_fmt);
        end
    end

    // integer move commit
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            int_move_we   <= 1'b0;
            int_move_data <= 32'h0000_0000;
        end else begin
            int_move_we   <= op_valid && !stall && move_go && !is_fmove && !is_branch;
            int_move_data <= src_value;
        end
    end

    // branch resolution
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            branch_taken       <= 1'b0;
            branch_target      <= 32'h0000_0000;
            delay_slot_nullify <= 1'b0;
        end else begin
            // target relative to delay slot, slot runs first
            branch_taken       <= op_valid && is_branch && br_go && !stall;
            branch_target      <= branch_pc + 32'h0000_0004 + branch_offset;
            delay_slot_nullify <= op_valid && is_likely && !br_go && !stall;
        end
    end

endmodule : fpu_exception_and_cond_move

// ---- tb/fpu_exc_checker.sv ----
// Purpose: port assertions for the fp exception unit
// Assumes: status layout from the params header
// Notes:   bound to the unit top below
`timescale 1ns/1ps
`include "fpu_exc_params.svh"

module fpu_exc_checker
    import fpu_exc_pkg::*;
(
    input wire logic        clk,                   // core clock
    input wire logic        rst_n,                 // async reset
    input wire logic        op_valid,              // op present
    input wire op_kind_e    op_kind,               // op kind
    input wire logic [5:0]  op_cond,               // raw conditions
    input wire logic        csr_wr,                // status write
    input wire logic [31:0] csr_wdata,             // written word
    input wire logic [31:0] fp_control_status_reg, // status word
    input wire logic        trap_req,              // trap request
    input wire logic        result_we,             // result commit
    input wire logic        int_move_we,           // int move commit
    input wire logic        branch_taken,          // redirect
    input wire logic        delay_slot_nullify     // slot kill
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    logic [4:0] flags;
    logic [5:0] cause;
    // status fields
    assign flags = fp_control_status_reg[6:2];
    assign cause = fp_control_status_reg[17:12];

    // ==========================================================
    // steps of an arithmetic op
    sequence s_arith;
        op_valid && op_kind == op_arith && !csr_wr;
    endsequence
    sequence s_quiet;
        s_arith ##0 !trap_req;
    endsequence

    // ==========================================================
    // assertions
    a_write_trap: assert property (csr_wr && |(csr_wdata[17:12] & {1'b1, csr_wdata[11:7]})
        |-> trap_req) else $error("enabled cause written without trap");
    a_op_trap: assert property (s_arith ##0 |(op_cond & {1'b1, fp_control_status_reg[11:7]})
        |-> trap_req) else $error("enabled condition without trap");
    a_trap_blocks: assert property (trap_req |=> !result_we && !int_move_we && !branch_taken)
        else $error("commit after trap");
    a_cause_rewrite: assert property (s_arith ##0 !op_cond[5] |=> cause == $past(op_cond))
        else $error("cause not rewritten");
    a_unimpl_alone: assert property (s_arith ##0 op_cond[5] |-> trap_req ##1 cause == 6'h20)
        else $error("unimplemented cause not alone");
    a_trap_flags: assert property (trap_req && !csr_wr |=> $stable(flags))
        else $error("flags moved on trap");
    a_flags_sticky: assert property (!csr_wr |=> (flags & $past(flags)) == $past(flags))
        else $error("flag cleared by op");
    a_quiet_commit: assert property (s_quiet |=> result_we)
        else $error("untrapped op not committed");
    a_nullify_kind: assert property (delay_slot_nullify |-> !branch_taken)
        else $error("nullify on taken branch");
endmodule : fpu_exc_checker

bind fpu_exception_and_cond_move fpu_exc_checker u_chk (.clk, .rst_n, .op_valid, .op_kind,
    .op_cond, .csr_wr, .csr_wdata, .fp_control_status_reg, .trap_req, .result_we,
    .int_move_we, .branch_taken, .delay_slot_nullify);

// ---- tb/int_pipe_model.sv ----
// Purpose: integer pipeline side, owns status writes
// Assumes: trap handler clears causes the cycle after a trap
// Notes:   handler write beats a bench write
`timescale 1ns/1ps

module int_pipe_model (
    input  wire logic        clk,       // core clock
    input  wire logic        rst_n,     // async reset
    input  wire logic        trap_req,  // trap from the unit
    input  wire logic [31:0] status,    // current status word
    input  wire logic        sw_wr,     // bench write request
    input  wire logic [31:0] sw_wdata,  // bench write word
    output logic             csr_wr,    // write strobe
    output logic [31:0]      csr_wdata  // written word
);
    logic clear_due;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) clear_due <= 1'b0;
        else clear_due <= trap_req && !clear_due;
    end
    // pick handler or bench write
    always_comb begin
        csr_wr    = clear_due || sw_wr;
        csr_wdata = clear_due ? (status & ~32'h0003_f000) : sw_wdata;
    end
endmodule : int_pipe_model

// ---- tb/fpu_exception_and_cond_move_tb.sv ----
// Purpose: self-checking bench for the fp exception unit
// Assumes: commit outputs one cycle after the op
// Notes:   pipeline model clears causes after traps
`timescale 1ns/1ps
`include "fpu_exc_params.svh"

module fpu_exception_and_cond_move_tb
    import fpu_exc_pkg::*;
;
    logic clk, rst_n, op_valid, op_sign, cmp_valid, cmp_true, sw_wr, csr_wr;
    logic trap_req, result_we, int_move_we, branch_taken, delay_slot_nullify, trap_seen;
    logic result_undef, cond_error, err_seen;
    op_kind_e op_kind;
    logic [5:0] op_cond;
    logic [2:0] cc_sel;
    logic [4:0] result_idx;
    logic [1:0] op_fmt;
    logic [31:0] sw_wdata, csr_wdata, status, result_data, int_move_data, branch_target, gpr_value;
    int fail_count = 0;
    int checked = 0;
    int cycles = 0;

    fpu_exception_and_cond_move DUT (.clk, .rst_n, .op_valid, .op_kind, .op_cond,
        .op_result(32'h3f80_0001), .op_sign, .cc_sel, .cmp_valid, .cmp_true,
        .gpr_value, .dst_idx(5'h07), .src_value(32'h4040_0000), .op_fmt,
        .branch_pc(32'h0000_1000), .branch_offset(32'h0000_0040), .csr_wr, .csr_wdata,
        .fp_control_status_reg(status), .trap_req, .result_we, .result_data, .result_idx,
        .result_undef, .int_move_we, .int_move_data, .branch_taken, .branch_target,
        .delay_slot_nullify, .cond_error);
    int_pipe_model u_pipe (.clk, .rst_n, .trap_req, .status, .sw_wr, .sw_wdata, .csr_wr,
        .csr_wdata);

    // ==========================================================
    // shared tasks
    task automatic check(input logic ok, input string msg);
        checked++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("FAIL at %0t: %s", $time, msg);
        end
    endtask : check
    task automatic stop_test();
        $display("mismatches %0d of %0d checks", fail_count, checked);
        if (fail_count == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : stop_test
    task automatic issue(input op_kind_e k, input logic [5:0] c, input logic s);
        @(posedge clk);
        op_valid <= 1'b1;
        op_kind  <= k;
        op_cond  <= c;
        op_sign  <= s;
        #1 trap_seen = trap_req;
        err_seen = cond_error;
        @(posedge clk);
        op_valid <= 1'b0;
        #1;
    endtask : issue
    task automatic wr_csr(input logic [31:0] w);
        @(posedge clk);
        sw_wr    <= 1'b1;
        sw_wdata <= w;
        #1 trap_seen = trap_req;
        @(posedge clk);
        sw_wr <= 1'b0;
        #1;
    endtask : wr_csr
    task automatic set_cc(input logic [2:0] i, input logic v);
        @(posedge clk);
        cmp_valid <= 1'b1;
        cc_sel    <= i;
        cmp_true  <= v;
        @(posedge clk);
        cmp_valid <= 1'b0;
        #1 check(status[(i == 0) ? 23 : 24 + i] === v, "cc bit position");
    endtask : set_cc
    function automatic logic [31:0] ovf(input logic [1:0] rm, input logic s);
        case (rm)
            `RM_NEAREST: return {s, `SP_INF};
            `RM_NOUGHT:  return {s, `SP_MAXFIN};
            `RM_UP:      return s ? {1'b1, `SP_MAXFIN} : {1'b0, `SP_INF};
            default:     return s ? {1'b1, `SP_INF} : {1'b0, `SP_MAXFIN};
        endcase
    endfunction : ovf
    function automatic logic [31:0] unf(input logic [1:0] rm, input logic s);
        case (rm)
            `RM_UP:   return s ? {1'b0, `SP_ZERO} : {1'b0, `SP_SMALLEST_NORMAL_VALUE};
            `RM_DOWN: return s ? {1'b1, `SP_SMALLEST_NORMAL_VALUE} : {1'b1, `SP_ZERO};
            default:  return {s, `SP_ZERO};
        endcase
    endfunction : unf

    // ==========================================================
    // scenarios
    task automatic t_inexact();
        wr_csr(32'h0);
        issue(op_arith, 6'h01, 1'b0);
        check(result_we === 1'b1 && result_data === 32'h3f80_0001, "rounded result");
        check(status[17:12] === 6'h01 && status[6:2] === 5'h01, "cause and flag");
        issue(op_arith, 6'h00, 1'b0);
        check(status[17:12] === 6'h00, "cause not cleared");
        check(status[6:2] === 5'h01, "flag lost");
    endtask : t_inexact
    task automatic t_defaults();
        for (int m = 0; m < 4; m++) begin
            for (int s = 0; s < 2; s++) begin
                wr_csr({30'h0, m[1:0]});
                issue(op_arith, 6'h05, s[0]);
                check(result_data === ovf(m[1:0], s[0]), "overflow default");
                check(err_seen === 1'b0, "legal pair flagged");
                issue(op_arith, 6'h03, s[0]);
                check(result_data === unf(m[1:0], s[0]), "underflow default");
                issue(op_arith, 6'h08, s[0]);
                check(result_data === {s[0], `SP_INF}, "zero divide default");
            end
        end
        issue(op_arith, 6'h10, 1'b0);
        check(result_data === `SP_QNAN, "invalid default");
        issue(op_arith, 6'h0a, 1'b0);
        check(err_seen === 1'b1, "illegal pair not flagged");
    endtask : t_defaults
    task automatic t_trap();
        wr_csr(32'h0000_0200);
        issue(op_arith, 6'h04, 1'b0);
        check(trap_seen === 1'b1 && result_we === 1'b0, "enabled overflow");
        check(status[17:12] === 6'h04 && status[6:2] === 5'h00, "trap fields");
        @(posedge clk);
        #1 check(status[17:12] === 6'h00, "handler clear");
        wr_csr(32'h0);
        issue(op_arith, 6'h23, 1'b0);
        check(trap_seen === 1'b1 && result_we === 1'b0, "unimplemented trap");
        check(status[17:12] === 6'h20 && status[6:2] === 5'h00, "only unimpl");
        wr_csr(32'h0001_0800);
        check(trap_seen === 1'b1 && status[17:12] === 6'h10, "write trap");
    endtask : t_trap
    task automatic t_branch(input logic [2:0] i, input logic v);
        logic tk;
        logic lk;
        set_cc(i, v);
        for (int k = 9; k < 13; k++) begin
            tk = (k == 10 || k == 12) == v;
            lk = k > 10;
            issue(op_kind_e'(k), 6'h00, 1'b0);
            check(branch_taken === tk, "branch decision");
            check(!tk || branch_target === 32'h0000_1044, "branch target");
            check(delay_slot_nullify === (lk && !tk), "slot nullify");
        end
    endtask : t_branch
    task automatic t_moves();
        issue(fp_move_if_gpr_zero, 6'h00, 1'b0);
        check(result_we === 1'b1 && result_data === 32'h4040_0000, "gpr move");
        check(result_idx === 5'h07, "move index");
        issue(fp_plain_move, 6'h00, 1'b0);
        check(result_we === 1'b1, "plain move");
        issue(fp_move_if_cc_false, 6'h00, 1'b0);
        check(result_we === 1'b1, "cc move");
        issue(int_move_on_cc_false, 6'h00, 1'b0);
        check(int_move_we === 1'b1 && int_move_data === 32'h4040_0000, "int move");
        issue(int_move_on_cc_true, 6'h00, 1'b0);
        check(int_move_we === 1'b0, "int move held");
        @(posedge clk);
        op_fmt <= 2'h1;
        issue(fp_move_if_gpr_nonzero, 6'h00, 1'b0);
        check(result_we === 1'b0 && result_undef === 1'b1, "undefined after retag");
        @(posedge clk);
        gpr_value <= 32'h0000_0005;
        issue(fp_move_if_gpr_nonzero, 6'h00, 1'b0);
        check(result_we === 1'b1 && result_undef === 1'b0, "nonzero move");
        issue(fp_move_if_gpr_zero, 6'h00, 1'b0);
        check(result_we === 1'b0 && result_undef === 1'b0, "retagged held");
    endtask : t_moves

    // ==========================================================
    // clock, timeout and main sequence
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            stop_test();
        end
    end
    initial begin
        {rst_n, op_valid, op_sign, cmp_valid, cmp_true, sw_wr} = '0;
        op_kind = op_none;
        {op_cond, cc_sel, sw_wdata, gpr_value, op_fmt} = '0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_inexact();
        t_defaults();
        t_trap();
        t_branch(3'h3, 1'b1);
        t_branch(3'h0, 1'b0);
        t_moves();
        stop_test();
    end
endmodule : fpu_exception_and_cond_move_tb
